/* File: tb/rtr_afe_model.sv */
// behavioural front end: answers each start after a set latency
`timescale 1ns/1ps
module rtr_afe_model (
   input wire logic clk,
   input wire logic rstn,
   input wire rtr_pkg::rtr_afe_ctl_t ctl,
   input wire logic [9:0] d1,
   input wire logic [9:0] d2,
   input wire logic [9:0] dl,
   input wire logic [1:0] lat,
   output rtr_pkg::rtr_afe_res_t res
);
   import rtr_pkg::*;
   logic busy;
   logic sec;
   logic [2:0] cnt;
   // local answers alternate bit two, so only a true 16-sample mean matches
   logic alt;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy <= 1'b0;
         sec <= 1'b0;
         cnt <= 3'h0;
         alt <= 1'b0;
         res <= '0;
      end else begin
         res.done <= 1'b0;
         // data toggles outside done so a stale value is never mistaken
         res.data <= ~res.data;
         if (ctl.start) begin
            busy <= 1'b1;
            cnt <= {1'b0, lat};
            sec <= (ctl.bias == BIAS_SECOND_CURRENT_MULTIPLE);
         end else if (busy) begin
            if (cnt == 3'h0) begin
               busy <= 1'b0;
               res.done <= 1'b1;
               // phase answer depends on which multiple was applied
               if (ctl.channel == CH_LOCAL) alt <= ~alt;
               res.data <= (ctl.channel == CH_LOCAL) ? (dl ^ {7'h00, alt, 2'h0}) :
                  ((sec || ctl.bias == BIAS_SECOND_CURRENT_MULTIPLE) ? d2 : d1);
            end else begin
               cnt <= cnt - 3'h1;
               if (ctl.bias == BIAS_SECOND_CURRENT_MULTIPLE) sec <= 1'b1;
            end
         end
      end
   end
endmodule // rtr_afe_model

/* File: tb/rtr_core_chk.sv */
// port assertions for the remote temperature result block
`timescale 1ns/1ps
module rtr_core_chk (
   input wire logic CLK,
   input wire logic RESETN,
   input wire rtr_pkg::rtr_avs_req_t AVS_REQ,
   input wire logic [rtr_pkg::DATA_W-1:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire rtr_pkg::rtr_afe_ctl_t AFE_CTL,
   input wire rtr_pkg::rtr_afe_res_t AFE_RES
);
   import rtr_pkg::*;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   sequence one_wait;
      AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
   endsequence
   wait_first_a: assert property ($rose(AVS_REQ.read || AVS_REQ.write) |-> one_wait)
      else $error("request did not take exactly one wait cycle");
   no_wait_idle_a: assert property (!(AVS_REQ.read || AVS_REQ.write) |-> !AVS_WAITREQUEST)
      else $error("wait raised without a request");
   wait_single_a: assert property (AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("wait held longer than one cycle");
   read_upper_a: assert property ((AVS_REQ.read && !AVS_WAITREQUEST) |->
      AVS_READDATA[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   start_pulse_a: assert property (AFE_CTL.start |=> !AFE_CTL.start)
      else $error("start longer than one cycle");
   local_base_a: assert property (AFE_CTL.channel == CH_LOCAL |-> AFE_CTL.bias == BIAS_BASE)
      else $error("local channel with raised bias");
   start_follow_a: assert property (AFE_RES.done |-> ##[1:4] AFE_CTL.start)
      else $error("no new conversion after done");
   chan_legal_a: assert property (AFE_CTL.channel != 2'h3)
      else $error("illegal channel code");
endmodule // rtr_core_chk
bind rtr_core rtr_core_chk chk (.CLK(CLK), .RESETN(RESETN), .AVS_REQ(AVS_REQ),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .AFE_CTL(AFE_CTL), .AFE_RES(AFE_RES));

/* File: tb/testbench.sv */
// self-checking bench of the remote temperature result block
`timescale 1ns/1ps
module testbench;
   import rtr_pkg::*;
   logic CLK = 1'b0;
   logic RESETN = 1'b0;
   rtr_avs_req_t req = '0;
   logic [DATA_W-1:0] rdata;
   logic wq;
   rtr_afe_ctl_t ctl;
   rtr_afe_res_t res;
   logic [9:0] d1 = 10'h000, d2 = 10'h000, dl = 10'h000, va, vb, vc;
   logic [1:0] lat = 2'h0;
   logic [7:0] cr [3] = '{8'h00, 8'h00, 8'h00};
   logic [7:0] expq [$];
   int n_mismatch = 0;
   int n_compared = 0;
   rtr_core dut (.CLK(CLK), .RESETN(RESETN), .AVS_REQ(req), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wq), .AFE_CTL(ctl), .AFE_RES(res));
   rtr_afe_model afe (.clk(CLK), .rstn(RESETN), .ctl(ctl), .d1(d1), .d2(d2), .dl(dl),
      .lat(lat), .res(res));
   initial forever #20 CLK = ~CLK;
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task bus(input logic w, input logic [7:0] idx, input logic [7:0] v);
      @(posedge CLK);
      req.read <= ~w;
      req.write <= w;
      req.address <= {idx, 2'h0};
      req.writedata <= {24'h000000, v};
      if (!w) expq.push_back(v);
      @(posedge CLK iff !wq);
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask
   always @(posedge CLK) if (req.read && !wq) check(rdata, {24'h000000, expq.pop_front()});
   task wcor(input int ch, input logic [7:0] v);
      cr[ch] = v;
      bus(1'b1, IDX_REMOTE1_CORR + 8'(ch), v);
      bus(1'b0, IDX_REMOTE1_CORR + 8'(ch), v);
   endtask
   function logic [9:0] ev(input int ch);
      int r;
      // local mean of dl and dl with bit two flipped, eight of each
      r = (ch == 1) ? $signed(dl & 10'h3FB) + 2 : 2 * $signed(d1) - $signed(d2);
      r = r > 511 ? 511 : (r < -512 ? -512 : r);
      r = r + 2 * $signed(cr[ch]);
      r = r > 511 ? 511 : (r < -512 ? -512 : r);
      return r[9:0];
   endfunction
   task snap;
      va = ev(0);
      vb = ev(1);
      vc = ev(2);
   endtask
   task rdx;
      bus(1'b0, IDX_EXT_RES, {vc[1:0], vb[1:0], va[1:0], 2'h0});
   endtask
   task rdv;
      bus(1'b0, IDX_REMOTE1_VALUE, va[9:2]);
      bus(1'b0, IDX_LOCAL_VALUE, vb[9:2]);
      bus(1'b0, IDX_REMOTE2_VALUE, vc[9:2]);
   endtask
   task newdata;
      d1 <= 10'($urandom);
      d2 <= 10'($urandom);
      dl <= 10'($urandom);
      lat <= 2'($urandom);
   endtask
   initial begin
      #(40 * 20000);
      n_mismatch++;
      print_verdict;
   end
   initial begin
      void'($urandom(64291));
      repeat (2) @(posedge CLK);
      RESETN <= 1'b1;
      for (int ch = 0; ch < 3; ch++) bus(1'b0, IDX_REMOTE1_CORR + 8'(ch), CORR_RESET);
      bus(1'b1, 8'h10, 8'hFF);
      bus(1'b0, 8'h10, 8'h00);
      for (int ch = 0; ch < 3; ch++) wcor(ch, 8'($urandom));
      newdata;
      repeat (3000) @(posedge CLK);
      snap;
      rdx;
      rdv;
      // ext read freezes values; new data must stay hidden until all are read
      rdx;
      newdata;
      repeat (3000) @(posedge CLK);
      rdv;
      repeat (3000) @(posedge CLK);
      snap;
      rdx;
      rdv;
      bus(1'b1, IDX_CONFIG2, 8'h10);
      bus(1'b0, IDX_CONFIG2, 8'h10);
      wcor(0, 8'h7F);
      wcor(1, 8'h80);
      wcor(2, 8'h80);
      d1 <= 10'h1FF;
      d2 <= 10'h200;
      dl <= 10'h200;
      // shorter than an averaged pass over all three channels, so only single-conversion updates can match
      repeat (150) @(posedge CLK);
      snap;
      rdx;
      rdv;
      print_verdict;
   end
endmodule // testbench

/* File: verilog/rtr_core.sv */
// remote temperature sequencing, averaging, offset correction and register slave
// What this block does
// - A remote reading converts with bias toggled base/first multiple, then base/second multiple, and combines both differences.
// - Sixteen conversions of a channel are averaged before its value register is written.
// - Results are 10-bit twos complement: upper eight bits in the value register, two low bits in the extended resolution register.
// - Each stored result has the channel's 8-bit signed correction added automatically.
// - One correction step weighs half a degree, twice the quarter-degree result step.
// - Corrections for remote 1, local and remote 2 sit at indices 0x70, 0x71, 0x72 and reset to zero.
// - Reading the extended resolution register freezes the value registers until each has been read.
// - Bit four of configuration register 2 turns averaging off, so each update is one conversion.
`timescale 1ns/1ps
module rtr_core #(
   parameter int AVG_SHIFT = rtr_pkg::AVG_LOG2,
   parameter int COMB_W1 = 2,
   parameter int COMB_W2 = 1,
   parameter int COMB_SHIFT = 0
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire rtr_pkg::rtr_avs_req_t AVS_REQ,
   output logic [rtr_pkg::DATA_W-1:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output rtr_pkg::rtr_afe_ctl_t AFE_CTL,
   input wire rtr_pkg::rtr_afe_res_t AFE_RES
);
   import rtr_pkg::*;

   localparam int ACC_W = TEMP_W + AVG_SHIFT;
   localparam int WIDE_W = 16;
   localparam int CNT_W = AVG_SHIFT + 1;
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(1 << AVG_SHIFT);

   generate
      if (AVG_SHIFT < 1 || AVG_SHIFT > 5 || COMB_W1 < 1 || COMB_W1 > 7 ||
          COMB_W2 < 0 || COMB_W2 > 7 || COMB_SHIFT < 0 || COMB_SHIFT > 3) begin : g_bad
         $error("rtr_core: unsupported parameter value");
      end
   endgenerate

   typedef struct packed {
      rtr_state_t st;
      rtr_chan_t chan;
      logic [CNT_W-1:0] cnt;
      logic signed [ACC_W-1:0] acc;
      logic signed [TEMP_W-1:0] dv1;
      logic [CHAN_N-1:0][TEMP_W-1:0] temp;
      logic [CHAN_N-1:0][CORR_W-1:0] corr;
      logic [7:0] config2;
      logic freeze;
      logic [CHAN_N-1:0] seen;
      logic ack;
      logic [DATA_W-1:0] rdata;
      logic start;
      logic chop;
   } rtr_regs_t;

   rtr_regs_t r;
   rtr_regs_t next_r;

   function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
      reg_index = addr[ADDR_W-1:BYTE_SEL_W];
   endfunction

   function automatic logic signed [TEMP_W-1:0] sat_temp(input logic signed [WIDE_W-1:0] v);
      logic signed [WIDE_W-1:0] hi;
      logic signed [WIDE_W-1:0] lo;
      hi = WIDE_W'(signed'({1'b0, {(TEMP_W-1){1'b1}}}));
      lo = -hi - WIDE_W'(1);
      if (v > hi) begin
         sat_temp = TEMP_W'(hi);
      end else if (v < lo) begin
         sat_temp = TEMP_W'(lo);
      end else begin
         sat_temp = TEMP_W'(v);
      end
   endfunction

   function automatic logic [DATA_W-1:0] read_mux(input rtr_regs_t s, input logic [IDX_W-1:0] idx);
      logic [7:0] ext;
      ext = 8'h00;
      ext[EXT_REMOTE1_LSB +: EXT_FIELD_W] = s.temp[CH_REMOTE1][EXT_FIELD_W-1:0];
      ext[EXT_LOCAL_LSB +: EXT_FIELD_W] = s.temp[CH_LOCAL][EXT_FIELD_W-1:0];
      ext[EXT_REMOTE2_LSB +: EXT_FIELD_W] = s.temp[CH_REMOTE2][EXT_FIELD_W-1:0];
      case (idx)
         IDX_REMOTE1_VALUE: read_mux = DATA_W'(s.temp[CH_REMOTE1][TEMP_W-1:EXT_FIELD_W]);
         IDX_LOCAL_VALUE: read_mux = DATA_W'(s.temp[CH_LOCAL][TEMP_W-1:EXT_FIELD_W]);
         IDX_REMOTE2_VALUE: read_mux = DATA_W'(s.temp[CH_REMOTE2][TEMP_W-1:EXT_FIELD_W]);
         IDX_REMOTE1_CORR: read_mux = DATA_W'(s.corr[CH_REMOTE1]);
         IDX_LOCAL_CORR: read_mux = DATA_W'(s.corr[CH_LOCAL]);
         IDX_REMOTE2_CORR: read_mux = DATA_W'(s.corr[CH_REMOTE2]);
         IDX_CONFIG2: read_mux = DATA_W'(s.config2);
         IDX_EXT_RES: read_mux = DATA_W'(ext);
         default: read_mux = READ_ZERO;
      endcase
   endfunction

   logic [IDX_W-1:0] idx;
   logic rd_done;
   logic wr_done;
   logic avg_off;
   logic [CNT_W-1:0] target;
   logic signed [WIDE_W-1:0] comb;
   logic signed [TEMP_W-1:0] sample;
   logic signed [TEMP_W-1:0] mean;
   logic signed [WIDE_W-1:0] corr_q;
   logic [CHAN_N-1:0] seen_now;

   assign AVS_WAITREQUEST = (AVS_REQ.read | AVS_REQ.write) & ~r.ack;
   assign AVS_READDATA = r.rdata;

   // bias alternates between the base current and the active multiple while a remote channel converts; local stays at base
   always_comb begin
      AFE_CTL.start = r.start;
      AFE_CTL.channel = r.chan;
      AFE_CTL.bias = BIAS_BASE;
      if (r.chop && r.chan != CH_LOCAL) begin
         if (r.st == ST_CONV1) begin
            AFE_CTL.bias = BIAS_FIRST_CURRENT_MULTIPLE;
         end else if (r.st == ST_CONV2) begin
            AFE_CTL.bias = BIAS_SECOND_CURRENT_MULTIPLE;
         end
      end
   end

   always_comb begin
      next_r = r;
      next_r.start = 1'b0;
      next_r.chop = 1'b0;
      idx = reg_index(AVS_REQ.address);
      rd_done = AVS_REQ.read & r.ack;
      wr_done = AVS_REQ.write & r.ack;
      avg_off = r.config2[CFG2_AVG_OFF_BIT];
      target = avg_off ? CNT_ONE : CNT_FULL;
      comb = WIDE_W'((WIDE_W'(signed'(r.dv1)) * COMB_W1 -
                      WIDE_W'(signed'(AFE_RES.data)) * COMB_W2) >>> COMB_SHIFT);
      sample = (r.chan == CH_LOCAL) ? signed'(AFE_RES.data) : sat_temp(comb);
      mean = avg_off ? TEMP_W'(r.acc) : TEMP_W'(r.acc >>> AVG_SHIFT);
      corr_q = WIDE_W'(signed'(r.corr[r.chan])) <<< 1;
      seen_now = r.seen;

      // register slave: answer one cycle after the request appears
      next_r.ack = (AVS_REQ.read | AVS_REQ.write) & ~r.ack;
      if ((AVS_REQ.read | AVS_REQ.write) && !r.ack) begin
         next_r.rdata = read_mux(r, idx);
      end
      if (wr_done) begin
         case (idx)
            IDX_REMOTE1_CORR: next_r.corr[CH_REMOTE1] = AVS_REQ.writedata[CORR_W-1:0];
            IDX_LOCAL_CORR: next_r.corr[CH_LOCAL] = AVS_REQ.writedata[CORR_W-1:0];
            IDX_REMOTE2_CORR: next_r.corr[CH_REMOTE2] = AVS_REQ.writedata[CORR_W-1:0];
            IDX_CONFIG2: next_r.config2 = AVS_REQ.writedata[7:0];
            default: next_r.config2 = r.config2;
         endcase
      end
      if (rd_done) begin
         case (idx)
            IDX_REMOTE1_VALUE: seen_now[CH_REMOTE1] = 1'b1;
            IDX_LOCAL_VALUE: seen_now[CH_LOCAL] = 1'b1;
            IDX_REMOTE2_VALUE: seen_now[CH_REMOTE2] = 1'b1;
            default: seen_now = r.seen;
         endcase
      end
      next_r.seen = seen_now;
      if (r.freeze && (&seen_now)) begin
         next_r.freeze = 1'b0;
      end
      // freeze from the cycle the low bits are latched, so no store slips in between
      if (AVS_REQ.read && !r.ack && idx == IDX_EXT_RES) begin
         next_r.freeze = 1'b1;
         next_r.seen = '0;
      end

      // conversion sequencer
      case (r.st)
         ST_IDLE: begin
            next_r.start = 1'b1;
            next_r.st = ST_CONV1;
         end
         ST_CONV1: begin
            next_r.chop = ~r.chop;
            if (AFE_RES.done) begin
               next_r.dv1 = AFE_RES.data;
               if (r.chan == CH_LOCAL) begin
                  next_r.st = ST_ACCUM;
               end else begin
                  next_r.start = 1'b1;
                  next_r.chop = 1'b0;
                  next_r.st = ST_CONV2;
               end
            end
         end
         ST_CONV2: begin
            next_r.chop = ~r.chop;
            if (AFE_RES.done) begin
               next_r.acc = r.acc + ACC_W'(sample);
               next_r.cnt = r.cnt + CNT_ONE;
               next_r.st = (r.cnt + CNT_ONE >= target) ? ST_STORE : ST_IDLE;
            end
         end
         ST_ACCUM: begin
            next_r.acc = r.acc + ACC_W'(signed'(r.dv1));
            next_r.cnt = r.cnt + CNT_ONE;
            next_r.st = (r.cnt + CNT_ONE >= target) ? ST_STORE : ST_IDLE;
         end
         ST_STORE: begin
            if (!next_r.freeze) begin
               next_r.temp[r.chan] = sat_temp(WIDE_W'(mean) + corr_q);
            end
            next_r.acc = '0;
            next_r.cnt = '0;
            next_r.chan = (r.chan == CH_REMOTE2) ? CH_REMOTE1 : rtr_chan_t'(r.chan + 2'h1);
            next_r.st = ST_IDLE;
         end
         default: next_r.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         r.st <= ST_IDLE;
         r.chan <= CH_REMOTE1;
         r.cnt <= '0;
         r.acc <= '0;
         r.dv1 <= TEMP_RESET;
         r.temp <= {CHAN_N{TEMP_RESET}};
         r.corr <= {CHAN_N{CORR_RESET}};
         r.config2 <= CONFIG2_RESET;
         r.freeze <= 1'b0;
         r.seen <= '0;
         r.ack <= 1'b0;
         r.rdata <= READ_ZERO;
         r.start <= 1'b0;
         r.chop <= 1'b0;
      end else begin
         r <= next_r;
      end
   end
endmodule // rtr_core

/* File: verilog/rtr_pkg.sv */
// shared constants, types and register map of the remote temperature result block
package rtr_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int TEMP_W = 10;
   localparam int CORR_W = 8;
   localparam int IDX_W = 8;
   localparam int CHAN_N = 3;

   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_REMOTE1_VALUE = 8'h25;
   localparam logic [IDX_W-1:0] IDX_LOCAL_VALUE = 8'h26;
   localparam logic [IDX_W-1:0] IDX_REMOTE2_VALUE = 8'h27;
   localparam logic [IDX_W-1:0] IDX_REMOTE1_CORR = 8'h70;
   localparam logic [IDX_W-1:0] IDX_LOCAL_CORR = 8'h71;
   localparam logic [IDX_W-1:0] IDX_REMOTE2_CORR = 8'h72;
   localparam logic [IDX_W-1:0] IDX_CONFIG2 = 8'h73;
   localparam logic [IDX_W-1:0] IDX_EXT_RES = 8'h77;
   localparam int BYTE_SEL_W = 2;

   localparam int CFG2_AVG_OFF_BIT = 4;
   localparam int EXT_REMOTE1_LSB = 2;
   localparam int EXT_LOCAL_LSB = 4;
   localparam int EXT_REMOTE2_LSB = 6;
   localparam int EXT_FIELD_W = 2;

   localparam logic [CORR_W-1:0] CORR_RESET = 8'h00;
   localparam logic [7:0] CONFIG2_RESET = 8'h00;
   localparam logic [TEMP_W-1:0] TEMP_RESET = 10'h000;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

   localparam int AVG_LOG2 = 4;  // 16 conversions per averaged result

   typedef enum logic [1:0] {
      BIAS_BASE = 2'h0,
      BIAS_FIRST_CURRENT_MULTIPLE = 2'h1,
      BIAS_SECOND_CURRENT_MULTIPLE = 2'h2
   } rtr_bias_t;

   typedef enum logic [1:0] {
      CH_REMOTE1 = 2'h0,
      CH_LOCAL = 2'h1,
      CH_REMOTE2 = 2'h2
   } rtr_chan_t;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_CONV1 = 5'h02,
      ST_CONV2 = 5'h04,
      ST_ACCUM = 5'h08,
      ST_STORE = 5'h10
   } rtr_state_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
   } rtr_avs_req_t;

   typedef struct packed {
      logic start;
      rtr_chan_t channel;
      rtr_bias_t bias;
   } rtr_afe_ctl_t;

   typedef struct packed {
      logic done;
      logic [TEMP_W-1:0] data;
   } rtr_afe_res_t;
endpackage
